// file: hw/ag1cir_pkg.sv
// package for the aliased group 1 cpu interface register block
package ag1cir_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_SPLIT_ALIAS = 12'h01C;
  localparam logic [11:0] OFS_ACK_ALIAS = 12'h020;
  localparam logic [11:0] OFS_DONE_ALIAS = 12'h024;
  localparam logic [11:0] OFS_PEND_ALIAS = 12'h028;
  // ---------------------------------------------------------------
  // field layout and special values
  // ---------------------------------------------------------------
  localparam int SPLIT_W = 3;
  localparam int INTERRUPT_NUMBER_W = 24;
  localparam int SGI_SRC_LO = 10;
  localparam int SGI_SRC_W = 3;
  localparam int SGI_ZERO_LO = 13;
  localparam logic [23:0] INTERRUPT_NUMBER_SPECIAL_LO = 24'h0003FC;
  localparam logic [23:0] INTERRUPT_NUMBER_NONE = 24'h0003FF;
  localparam logic [23:0] SGI_LIMIT = 24'h000010;
  localparam logic [2:0] SPLIT_ONE = 3'h1;
  localparam logic [2:0] SPLIT_MAX = 3'h7;
  localparam logic [31:0] READ_ZERO = 32'h00000000;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic write;
    logic secure;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ag1cir_req_type;
  typedef struct packed {
    logic valid;
    logic group1;
    logic [23:0] interrupt_number;
    logic [2:0] source_cpu;
  } ag1cir_pend_type;
  typedef struct packed {
    logic valid;
    logic drop;
    logic deact;
    logic [23:0] interrupt_number;
  } ag1cir_done_type;
endpackage : ag1cir_pkg

// file: hw/ag1cir_top.sv
// aliased group 1 cpu interface register block
`timescale 1ns/1ps
// What this block does
// R01: alias reaches nonsecure copy of split point
// R02: nonsecure reads return shifted split value
// R03: common select steers secure access to group0
// R04: split field bits 2:0, rest zero
// R05: split field needs no reset value
// R06: completion write drops priority, maybe deactivates
// R07: secure alias access equals nonsecure ordinary
// R08: interrupt number bits 23:0, top zero
// R09: numbers 1020-1023 are special, never real
// R10: no affinity: upper zero, source only SOFTWARE_GENERATED_INTERRUPT
// R11: software writes back last acknowledged number
// R12: pending view shows group 1 top number
// R13: group 0 top pending reads 1023
// R14: disabled groups ignored for pending view
// R15: group disabled at interface reads 1023
// R16: acknowledge read returns number, acknowledges it
// R17: no memory-mapped use with affinity routing; the block does not gate on AFFINITY_ROUTING and assumes it off
// R18: aliases serve only without system register access
// R19: completion mode set: drop only, no deactivate
// R20: common select: one split governs both groups
// R21: write-only reads zero, read-only writes ignored
module ag1cir_top (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic CLK_EN,
  input wire ag1cir_pkg::ag1cir_req_type REQ,
  input wire ag1cir_pkg::ag1cir_pend_type PEND,
  input wire logic GROUP0_ENABLE,
  input wire logic GROUP1_ENABLE,
  input wire logic SECURITY_DISABLE,
  input wire logic SYSREG_ENABLE,
  input wire logic AFFINITY_ROUTING,
  input wire logic MONITOR_COMMON_SPLIT_SELECT,
  input wire logic COMMON_SPLIT_POINT_SELECT,
  input wire logic NONSECURE_COMPLETION_MODE,
  input wire logic [2:0] GROUP0_SPLIT,
  output logic [31:0] RDATA,
  output logic RVALID,
  output logic ACK_PULSE,
  output ag1cir_pkg::ag1cir_done_type DONE,
  output logic GROUP0_SPLIT_WE,
  output logic [2:0] GROUP0_SPLIT_WDATA,
  output logic [2:0] GROUP1_SPLIT,
  output logic [2:0] PREEMPT_SPLIT_GROUP1
);
  import ag1cir_pkg::*;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic [23:0] shape_interrupt_number(input logic [23:0] id, input logic [2:0] src, input logic aff);
    logic [23:0] r;
    r = id;
    if (!aff) begin
      r[INTERRUPT_NUMBER_W-1:SGI_ZERO_LO] = '0; // [R10]
      r[SGI_SRC_LO +: SGI_SRC_W] = (id < SGI_LIMIT) ? src : 3'h0; // [R10]
    end
    return r;
  endfunction : shape_interrupt_number

  function automatic logic is_special(input logic [23:0] id);
    return id >= INTERRUPT_NUMBER_SPECIAL_LO && id <= INTERRUPT_NUMBER_NONE;
  endfunction : is_special

  logic [2:0] split_ns_reg; // [R05] no reset value forced
  wire logic live = REQ.valid && !SYSREG_ENABLE; // [R18] [R17] affinity assumed off
  wire logic hit_split = live && REQ.addr == OFS_SPLIT_ALIAS;
  wire logic hit_ack = live && REQ.addr == OFS_ACK_ALIAS;
  wire logic hit_done = live && REQ.addr == OFS_DONE_ALIAS;
  wire logic hit_pend = live && REQ.addr == OFS_PEND_ALIAS;
  wire logic two_states = !SECURITY_DISABLE;
  // secure access goes to group 0 copy when monitor select is set
  wire logic to_group0 = two_states && REQ.secure && MONITOR_COMMON_SPLIT_SELECT; // [R03]
  // nonsecure view is the stored value plus one, saturating
  wire logic [2:0] split_shifted = (split_ns_reg == SPLIT_MAX) ? SPLIT_MAX : split_ns_reg + SPLIT_ONE; // [R02]
  wire logic [2:0] split_wr_ns = (REQ.wdata[2:0] == 3'h0) ? 3'h0 : REQ.wdata[2:0] - SPLIT_ONE;
  wire logic [2:0] split_read = to_group0 ? GROUP0_SPLIT : ((two_states && !REQ.secure) ? split_shifted : split_ns_reg);
  wire logic group_ok = PEND.group1 ? GROUP1_ENABLE : GROUP0_ENABLE; // [R14]
  wire logic pend_real = PEND.valid && group_ok && !is_special(PEND.interrupt_number); // [R09]
  wire logic [23:0] pend_id = (pend_real && PEND.group1) ? PEND.interrupt_number : INTERRUPT_NUMBER_NONE; // [R12] [R13] [R15]
  wire logic [23:0] pend_shaped = shape_interrupt_number(pend_id, PEND.source_cpu, AFFINITY_ROUTING);
  wire logic ack_real = hit_ack && !REQ.write && pend_real && PEND.group1; // [R16]
  wire logic [31:0] rd_val =
    (hit_split) ? {29'h0, split_read} : // [R04] [R01]
    (hit_ack || hit_pend) ? {8'h00, pend_shaped} : READ_ZERO; // [R08] [R07] [R21]
  wire logic done_fire = hit_done && REQ.write; // [R06]
  wire logic [23:0] done_id = REQ.wdata[INTERRUPT_NUMBER_W-1:0];

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (CLK_EN && hit_split && REQ.write && !to_group0) begin
      split_ns_reg <= (two_states && !REQ.secure) ? split_wr_ns : REQ.wdata[2:0]; // [R01] [R04]
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      RDATA <= READ_ZERO;
      RVALID <= 1'b0;
      ACK_PULSE <= 1'b0;
      DONE <= '0;
      GROUP0_SPLIT_WE <= 1'b0;
      GROUP0_SPLIT_WDATA <= 3'h0;
    end else if (CLK_EN) begin
      RVALID <= live && !REQ.write;
      RDATA <= REQ.write ? READ_ZERO : rd_val; // [R21]
      ACK_PULSE <= ack_real; // [R16]
      DONE.valid <= done_fire && !is_special(done_id); // [R09]
      DONE.drop <= done_fire && !is_special(done_id); // [R06]
      DONE.deact <= done_fire && !is_special(done_id) && !NONSECURE_COMPLETION_MODE; // [R06] [R19] [R07]
      DONE.interrupt_number <= done_id;
      GROUP0_SPLIT_WE <= hit_split && REQ.write && to_group0; // [R03]
      GROUP0_SPLIT_WDATA <= REQ.wdata[2:0];
    end
  end

  // split outputs; common select lets group 0 value drive PREEMPT_SPLIT_GROUP1, GROUP1_SPLIT stays the stored copy
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      GROUP1_SPLIT <= 3'h0;
      PREEMPT_SPLIT_GROUP1 <= 3'h0;
    end else if (CLK_EN) begin
      GROUP1_SPLIT <= split_ns_reg;
      PREEMPT_SPLIT_GROUP1 <= COMMON_SPLIT_POINT_SELECT ? GROUP0_SPLIT : split_ns_reg; // [R20]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_PEND_G0: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R13]
    CLK_EN && hit_pend && !REQ.write && PEND.valid && !PEND.group1 |=> RDATA == {8'h00, INTERRUPT_NUMBER_NONE})
    else $error("group 0 pending not 1023");
  AST_PEND_DIS: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R15]
    CLK_EN && hit_pend && !REQ.write && PEND.group1 && !GROUP1_ENABLE |=> RDATA[23:0] == INTERRUPT_NUMBER_NONE)
    else $error("disabled group not 1023");
  AST_TOP_ZERO: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R08]
    RVALID |-> RDATA[31:24] == 8'h00)
    else $error("reserved bits nonzero");
  AST_DONE_RD: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R21]
    CLK_EN && hit_done && !REQ.write |=> RDATA == READ_ZERO && RVALID)
    else $error("completion read not zero");
  AST_DROP: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R06]
    CLK_EN && done_fire && !is_special(done_id) && !NONSECURE_COMPLETION_MODE |=> DONE.drop && DONE.deact)
    else $error("completion missed deactivate");
  AST_DROP_ONLY: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R19]
    CLK_EN && done_fire && NONSECURE_COMPLETION_MODE |=> !DONE.deact)
    else $error("deactivate in split mode");
  AST_SYSREG: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R18]
    CLK_EN && SYSREG_ENABLE |=> !RVALID && !ACK_PULSE && !DONE.valid)
    else $error("alias active with system registers");
  AST_ACK: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R16]
    ACK_PULSE |-> RVALID && RDATA[23:0] != INTERRUPT_NUMBER_NONE)
    else $error("acknowledge without number");
  AST_SPLIT_G0: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R03]
    CLK_EN && hit_split && REQ.write && to_group0 |=> GROUP0_SPLIT_WE && $stable(split_ns_reg))
    else $error("secure split write not redirected");
  // ---------------------------------------------------------------
  // answer timing and refusals
  // ---------------------------------------------------------------
  AST_RD_ANSWER: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R18]
    CLK_EN && live && !REQ.write |=> RVALID)
    else $error("read not answered");
  AST_WR_SILENT: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R21]
    CLK_EN && REQ.valid && REQ.write |=> !RVALID)
    else $error("write produced read answer");
  AST_ACK_WR: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R21]
    CLK_EN && hit_ack && REQ.write |=> !ACK_PULSE)
    else $error("write to acknowledge alias acknowledged");
  AST_ACK_DATA: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R16]
    CLK_EN && ack_real |=> ACK_PULSE && RDATA[23:0] == $past(pend_shaped))
    else $error("acknowledge data mismatch");
  // ---------------------------------------------------------------
  // interrupt number shaping
  // ---------------------------------------------------------------
  AST_SPECIAL_ACK: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R09]
    ACK_PULSE |-> !is_special(RDATA[23:0]))
    else $error("special number acknowledged");
  AST_SPECIAL_DONE: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R09]
    CLK_EN && done_fire && is_special(done_id) |=> !DONE.valid)
    else $error("special number completed");
  AST_AFF_OFF: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R10]
    CLK_EN && (hit_ack || hit_pend) && !REQ.write && !AFFINITY_ROUTING |=> RDATA[23:13] == '0)
    else $error("upper number bits set without affinity");
  AST_PEND_G1: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R12]
    CLK_EN && hit_pend && !REQ.write && pend_real && PEND.group1 |=> RDATA[9:0] == $past(PEND.interrupt_number[9:0]))
    else $error("group 1 pending number lost");
  // ---------------------------------------------------------------
  // split point and completion
  // ---------------------------------------------------------------
  AST_SHIFT: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R02]
    CLK_EN && hit_split && !REQ.write && two_states && !REQ.secure && split_ns_reg != SPLIT_MAX
    |=> RDATA[2:0] == $past(split_ns_reg) + SPLIT_ONE)
    else $error("nonsecure split not shifted");
  AST_SPLIT_TOP: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R04]
    CLK_EN && hit_split && !REQ.write |=> RDATA[31:3] == '0)
    else $error("split reserved bits nonzero");
  AST_PREEMPT: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R20]
    CLK_EN && COMMON_SPLIT_POINT_SELECT |=> PREEMPT_SPLIT_GROUP1 == $past(GROUP0_SPLIT))
    else $error("common split not followed");
  AST_DEACT_DROP: assert property (@(posedge SYS_CLK) disable iff (RESET) // [R06]
    DONE.deact |-> DONE.drop && DONE.valid)
    else $error("deactivate without drop");
endmodule : ag1cir_top

// file: bench/ag1cir_pe_model.sv
// processing element model: keeps the last acknowledged number
`timescale 1ns/1ps
module ag1cir_pe_model (
  input wire logic clk,
  input wire logic ack_pulse,
  input wire logic [31:0] rdata,
  output logic [31:0] last_ack
);
  // completion writes echo this value, except the one special-number write of 3FC
  always_ff @(posedge clk) begin
    if (ack_pulse) begin
      last_ack <= rdata;
    end
  end
endmodule : ag1cir_pe_model

// file: bench/test_aliased_group1_cpu_if_regs.sv
// self-checking bench for the aliased group 1 register block
`timescale 1ns/1ps
module test_aliased_group1_cpu_if_regs;
  import ag1cir_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  ag1cir_req_type req = '0;
  ag1cir_pend_type pend = '0;
  logic g1_en = 1'b1, sysreg = 1'b0, mon_sel = 1'b0, com_sel = 1'b0, ns_mode = 1'b0, sec_dis = 1'b0;
  logic [31:0] rdata, last_ack, rd_s;
  logic rvalid, ack, g0_we, rv_s, ack_s, we_s;
  logic [2:0] g0_wd, g1_split, pre_split;
  ag1cir_done_type done, dn_s;
  int n_fail = 0;
  int comparisons = 0;
  always #2.5 clk = ~clk;
  ag1cir_top uut (.SYS_CLK(clk), .RESET(rst), .CLK_EN(1'b1), .REQ(req), .PEND(pend), .GROUP0_ENABLE(1'b1),
    .GROUP1_ENABLE(g1_en), .SECURITY_DISABLE(sec_dis), .SYSREG_ENABLE(sysreg),
    .AFFINITY_ROUTING(1'b0), // software keeps affinity routing off
    .MONITOR_COMMON_SPLIT_SELECT(mon_sel), .COMMON_SPLIT_POINT_SELECT(com_sel),
    .NONSECURE_COMPLETION_MODE(ns_mode), .GROUP0_SPLIT(3'h5), .RDATA(rdata), .RVALID(rvalid),
    .ACK_PULSE(ack), .DONE(done), .GROUP0_SPLIT_WE(g0_we), .GROUP0_SPLIT_WDATA(g0_wd),
    .GROUP1_SPLIT(g1_split), .PREEMPT_SPLIT_GROUP1(pre_split));
  ag1cir_pe_model pe (.clk(clk), .ack_pulse(ack), .rdata(rdata), .last_ack(last_ack));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one request, then three cycles of watching the answer pulses
  task automatic access(input logic w, input logic s, input logic [11:0] a, input logic [31:0] d);
    rv_s = 1'b0; ack_s = 1'b0; we_s = 1'b0; dn_s = '0; rd_s = '0;
    @(posedge clk);
    req <= '{valid: 1'b1, write: w, secure: s, addr: a, wdata: d};
    @(posedge clk);
    req.valid <= 1'b0;
    repeat (3) begin
      #1;
      rv_s |= rvalid; ack_s |= ack; we_s |= g0_we;
      if (rvalid === 1'b1) rd_s = rdata;
      if (done.valid === 1'b1) dn_s = done;
      @(posedge clk);
    end
  endtask : access
  task automatic final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_split;
    access(1'b1, 1'b0, OFS_SPLIT_ALIAS, 32'hFFFFFFF3);
    check(g1_split, 32'h2);
    access(1'b0, 1'b0, OFS_SPLIT_ALIAS, '0);
    check(rd_s, 32'h3);
    access(1'b0, 1'b1, OFS_SPLIT_ALIAS, '0);
    check(rd_s, 32'h2);
    mon_sel <= 1'b1;
    access(1'b1, 1'b1, OFS_SPLIT_ALIAS, 32'h6);
    check({we_s, g0_wd}, 32'hE);
    access(1'b0, 1'b1, OFS_SPLIT_ALIAS, '0);
    check(rd_s, 32'h5);
    com_sel <= 1'b1;
    access(1'b0, 1'b0, OFS_DONE_ALIAS, '0);
    check(rd_s, 32'h0);
    check(pre_split, 32'h5);
    sec_dis <= 1'b1;
    access(1'b0, 1'b0, OFS_SPLIT_ALIAS, '0);
    check(rd_s, 32'h2);
    sec_dis <= 1'b0;
  endtask : t_split
  task automatic t_ack;
    pend <= '{valid: 1'b1, group1: 1'b1, interrupt_number: 24'h000005, source_cpu: 3'h3};
    access(1'b0, 1'b1, OFS_ACK_ALIAS, '0);
    check(rd_s, 32'hC05);
    check(ack_s, 32'h1);
    pend.interrupt_number <= 24'h123456;
    access(1'b0, 1'b0, OFS_PEND_ALIAS, '0);
    check(rd_s, 32'h56);
    access(1'b1, 1'b0, OFS_ACK_ALIAS, 32'h5);
    check({rv_s, ack_s}, 32'h0);
    pend.interrupt_number <= INTERRUPT_NUMBER_SPECIAL_LO;
    access(1'b0, 1'b0, OFS_ACK_ALIAS, '0);
    check(ack_s, 32'h0);
    pend.group1 <= 1'b0;
    pend.interrupt_number <= 24'h000021;
    access(1'b0, 1'b0, OFS_PEND_ALIAS, '0);
    check(rd_s, 32'h3FF);
    pend.group1 <= 1'b1;
    g1_en <= 1'b0;
    access(1'b0, 1'b0, OFS_PEND_ALIAS, '0);
    check(rd_s, 32'h3FF);
    g1_en <= 1'b1;
  endtask : t_ack
  task automatic t_done;
    access(1'b1, 1'b1, OFS_DONE_ALIAS, last_ack);
    check({dn_s.valid, dn_s.drop, dn_s.deact, dn_s.interrupt_number}, {3'h7, 24'h000C05});
    ns_mode <= 1'b1;
    access(1'b1, 1'b0, OFS_DONE_ALIAS, last_ack);
    check({dn_s.valid, dn_s.drop, dn_s.deact}, 32'h6);
    access(1'b1, 1'b0, OFS_DONE_ALIAS, 32'h3FC);
    check(dn_s.valid, 32'h0);
    sysreg <= 1'b1;
    access(1'b0, 1'b0, OFS_ACK_ALIAS, '0);
    check({rv_s, ack_s}, 32'h0);
  endtask : t_done
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_split();
    t_ack();
    t_done();
    final_report();
  end
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule : test_aliased_group1_cpu_if_regs
